// ### design/ratrk_tracker.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module ratrk_tracker import ratrk_pkg::*; (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [RATRK_AW-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// resolver samples from the converter logic, same clock
	input wire logic signed [RATRK_DW-1:0] sin_sample_i,
	input wire logic signed [RATRK_DW-1:0] cos_sample_i,
	// peer channel
	input wire logic link_req_i,
	output logic link_req_o,
	// results and requests
	output logic signed [RATRK_DW-1:0] angle_o,
	output logic signed [RATRK_DW-1:0] speed_o,
	output logic result_valid_o,
	output logic dma_req_o,
	output logic irq_o,
	// converter sync
	output logic pwm_o
);

	typedef struct packed {
		ratrk_fsm_t st;
		logic master;
		logic periodic;
		logic link_en;
		logic [15:0] period;
		logic [15:0] duty;
		logic [15:0] delay;
		logic [15:0] speed_gain_mantissa;
		logic [3:0] speed_gain_shift;
		logic [15:0] angle_gain_mantissa;
		logic [3:0] angle_gain_shift;
		logic [7:0] rate_irq;
		logic [7:0] rate_link;
		logic [1:0] status;
		logic [1:0] mask;
		logic signed [15:0] speed;
		logic signed [15:0] position_accumulator;
		logic signed [15:0] theta;
		logic signed [15:0] err;
		logic signed [15:0] angle_out;
		logic signed [15:0] speed_out;
		logic [15:0] pcnt;
		logic [7:0] icnt;
		logic [7:0] lcnt;
		logic pend;
		logic valid;
		logic dma;
		logic link;
		logic pwm;
		logic [31:0] rdata;
	} ratrk_state_t;

	ratrk_state_t s, n;
	logic signed [15:0] rom_sin;
	logic signed [15:0] rom_cos;

	// saturate a wide signed value into one fraction
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7fff) begin
			return 16'sh7fff;
		end else if (v < -48'sh8000) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction : sat16

	// full product of two fractions
	function automatic logic signed [47:0] qmul(input logic signed [15:0] a, input logic signed [15:0] b);
		return 48'(a * b);
	endfunction : qmul

	// iteration counter; a rate of zero behaves as one
	function automatic logic rate_hit(input logic [7:0] cnt, input logic [7:0] rate);
		return (cnt + 8'h01) >= ((rate == 8'h00) ? 8'h01 : rate);
	endfunction : rate_hit

	// phase of the estimate feeds the table; two's complement wrap covers the turn
	ratrk_trig_rom u_rom (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.phase_i(s.theta[15:15-RATRK_PHW+1]),
		.sin_o(rom_sin),
		.cos_o(rom_cos)
	);

	always_comb begin
		logic per_trig;
		logic cmd_go;
		logic cmd_rst;
		logic trig;
		logic signed [47:0] w;
		logic signed [15:0] spd_new;
		logic signed [15:0] acc_new;
		per_trig = 1'b0;
		cmd_go = 1'b0;
		cmd_rst = 1'b0;
		trig = 1'b0;
		w = '0;
		spd_new = '0;
		acc_new = '0;
		n = s;
		n.valid = 1'b0;
		n.dma = 1'b0;
		n.link = 1'b0;

		// register writes steer modes, gains and timing
		if (wr_i) begin
			case (addr_i)
				RATRK_CTRL: begin
					n.master = wdata_i[RATRK_CTRL_MASTER];
					n.periodic = wdata_i[RATRK_CTRL_PERIODIC];
					n.link_en = wdata_i[RATRK_CTRL_LINK];
				end
				RATRK_CMD: begin
					cmd_go = wdata_i[RATRK_CMD_COMPUTE];
					cmd_rst = wdata_i[RATRK_CMD_RESET];
				end
				RATRK_PERIOD: n.period = wdata_i[15:0];
				RATRK_DUTY: n.duty = wdata_i[15:0];
				RATRK_DELAY: n.delay = wdata_i[15:0];
				RATRK_GAIN1: begin
					n.speed_gain_mantissa = wdata_i[15:0];
					n.speed_gain_shift = wdata_i[RATRK_GAIN_SHIFT_LSB +: 4];
				end
				RATRK_GAIN2: begin
					n.angle_gain_mantissa = wdata_i[15:0];
					n.angle_gain_shift = wdata_i[RATRK_GAIN_SHIFT_LSB +: 4];
				end
				RATRK_RATE: begin
					n.rate_irq = wdata_i[7:0];
					n.rate_link = wdata_i[RATRK_RATE_LINK_LSB +: 8];
				end
				RATRK_MASK: n.mask = wdata_i[1:0];
				default: n.rate_irq = s.rate_irq;
			endcase
		end

		// read data one cycle later; unmapped reads return zero
		n.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				RATRK_CTRL: n.rdata = {29'h0, s.link_en, s.periodic, s.master};
				RATRK_PERIOD: n.rdata = {16'h0000, s.period};
				RATRK_DUTY: n.rdata = {16'h0000, s.duty};
				RATRK_DELAY: n.rdata = {16'h0000, s.delay};
				RATRK_GAIN1: n.rdata = {12'h000, s.speed_gain_shift, s.speed_gain_mantissa};
				RATRK_GAIN2: n.rdata = {12'h000, s.angle_gain_shift, s.angle_gain_mantissa};
				RATRK_RATE: n.rdata = {16'h0000, s.rate_link, s.rate_irq};
				RATRK_STATUS: n.rdata = {30'h0, s.status};
				RATRK_MASK: n.rdata = {30'h0, s.mask};
				RATRK_ANGLE: n.rdata = {{16{s.angle_out[15]}}, s.angle_out};
				RATRK_SPEED: n.rdata = {{16{s.speed_out[15]}}, s.speed_out};
				RATRK_ERROR: n.rdata = {{16{s.err[15]}}, s.err};
				default: n.rdata = 32'h0000_0000;
			endcase
			// a status read clears; events below still set in the same cycle
			if (addr_i == RATRK_STATUS) begin
				n.status = 2'h0;
			end
		end

		// period counter runs only in master mode; follower mode leaves the pin low
		if (s.master) begin
			n.pcnt = (s.pcnt + 16'h0001 >= s.period) ? 16'h0000 : s.pcnt + 16'h0001;
		end else begin
			n.pcnt = 16'h0000;
		end
		n.pwm = n.master && (n.pcnt < n.duty);
		per_trig = s.master && s.periodic && (s.pcnt == s.delay);

		// a host command or incoming link request during an iteration sets one pending flag, served next unless an observer reset clears it
		trig = cmd_go || link_req_i || per_trig;

		case (s.st)
			st_idle: begin
				if (trig || s.pend) begin
					n.st = st_update;
					n.pend = 1'b0;
				end
			end
			st_update: begin
				n.pend = s.pend || trig;
				// speed integrates the previous error through the scaled first gain
				w = 48'(s.speed) + (qmul(s.err, signed'(s.speed_gain_mantissa)) >>> (RATRK_FRAC + s.speed_gain_shift));
				spd_new = sat16(w);
				// plain accumulation of the old speed, wrapping keeps angle modulo one turn
				acc_new = s.position_accumulator + s.speed;
				w = (qmul(signed'(s.angle_gain_mantissa), spd_new) >>> RATRK_FRAC) <<< s.angle_gain_shift;
				n.theta = sat16(w) + acc_new;
				n.speed = spd_new;
				n.position_accumulator = acc_new;
				n.st = st_lookup;
			end
			st_lookup: begin
				n.pend = s.pend || trig;
				n.st = st_error;
			end
			st_error: begin
				n.pend = s.pend || trig;
				// error is the sine of the angle difference, fed back through the scaled first gain
				w = (qmul(sin_sample_i, rom_cos) - qmul(cos_sample_i, rom_sin)) >>> RATRK_FRAC;
				n.err = sat16(w);
				n.angle_out = s.theta;
				n.speed_out = s.speed;
				n.valid = 1'b1;
				n.dma = 1'b1;
				n.status[RATRK_ST_DONE] = 1'b1;
				// request rates count iterations separately
				if (rate_hit(s.icnt, s.rate_irq)) begin
					n.icnt = 8'h00;
					n.status[RATRK_ST_IRQ] = 1'b1;
				end else begin
					n.icnt = s.icnt + 8'h01;
				end
				if (rate_hit(s.lcnt, s.rate_link)) begin
					n.lcnt = 8'h00;
					n.link = s.link_en;
				end else begin
					n.lcnt = s.lcnt + 8'h01;
				end
				n.st = st_idle;
			end
			default: n.st = st_idle;
		endcase

		// observer reset drops any iteration in progress
		if (cmd_rst) begin
			n.speed = 16'sh0000;
			n.position_accumulator = 16'sh0000;
			n.theta = 16'sh0000;
			n.err = 16'sh0000;
			n.pend = 1'b0;
			n.icnt = 8'h00;
			n.lcnt = 8'h00;
			n.st = st_idle;
			// an aborted iteration publishes nothing: no strobes,
			// last results stay on the outputs
			n.valid = 1'b0;
			n.dma = 1'b0;
			n.link = 1'b0;
			n.angle_out = s.angle_out;
			n.speed_out = s.speed_out;
			// a write never shares the cycle with a status read, so no clear is lost here
			n.status = s.status;
		end
	end

	// single register of all state
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.st <= st_idle;
			s.period <= RATRK_PERIOD_RST;
			s.duty <= RATRK_DUTY_RST;
			s.delay <= RATRK_DELAY_RST;
			s.speed_gain_mantissa <= RATRK_GAIN_M_RST;
			s.speed_gain_shift <= RATRK_GAIN_S_RST;
			s.angle_gain_mantissa <= RATRK_GAIN_M_RST;
			s.angle_gain_shift <= RATRK_GAIN_S_RST;
			s.rate_irq <= RATRK_RATE_RST;
			s.rate_link <= RATRK_RATE_RST;
			s.mask <= RATRK_MASK_RST;
		end else begin
			s <= n;
		end
	end

	// outputs; without host commands the estimate loop runs only in master periodic mode or on peer link requests
	assign rdata_o = s.rdata;
	assign angle_o = s.angle_out;
	assign speed_o = s.speed_out;
	assign result_valid_o = s.valid;
	assign dma_req_o = s.dma;
	assign link_req_o = s.link;
	assign irq_o = |(s.status & s.mask);
	assign pwm_o = s.pwm;

endmodule : ratrk_tracker

// ### inc/ratrk_pkg.sv
package ratrk_pkg;

	// data widths
	localparam int RATRK_DW = 16;
	localparam int RATRK_AW = 6;
	localparam int RATRK_PHW = 7;

	// register byte offsets
	localparam logic [5:0] RATRK_CTRL = 6'h00;
	localparam logic [5:0] RATRK_CMD = 6'h04;
	localparam logic [5:0] RATRK_PERIOD = 6'h08;
	localparam logic [5:0] RATRK_DUTY = 6'h0c;
	localparam logic [5:0] RATRK_DELAY = 6'h10;
	localparam logic [5:0] RATRK_GAIN1 = 6'h14;
	localparam logic [5:0] RATRK_GAIN2 = 6'h18;
	localparam logic [5:0] RATRK_RATE = 6'h1c;
	localparam logic [5:0] RATRK_STATUS = 6'h20;
	localparam logic [5:0] RATRK_MASK = 6'h24;
	localparam logic [5:0] RATRK_ANGLE = 6'h28;
	localparam logic [5:0] RATRK_SPEED = 6'h2c;
	localparam logic [5:0] RATRK_ERROR = 6'h30;

	// field positions
	localparam int RATRK_CTRL_MASTER = 0;
	localparam int RATRK_CTRL_PERIODIC = 1;
	localparam int RATRK_CTRL_LINK = 2;
	localparam int RATRK_CMD_COMPUTE = 0;
	localparam int RATRK_CMD_RESET = 1;
	localparam int RATRK_GAIN_SHIFT_LSB = 16;
	localparam int RATRK_RATE_LINK_LSB = 8;
	localparam int RATRK_ST_DONE = 0;
	localparam int RATRK_ST_IRQ = 1;

	// reset values
	localparam logic [15:0] RATRK_PERIOD_RST = 16'h03e8;
	localparam logic [15:0] RATRK_DUTY_RST = 16'h01f4;
	localparam logic [15:0] RATRK_DELAY_RST = 16'h0000;
	localparam logic [15:0] RATRK_GAIN_M_RST = 16'h4000;
	localparam logic [3:0] RATRK_GAIN_S_RST = 4'h0;
	localparam logic [7:0] RATRK_RATE_RST = 8'h01;
	localparam logic [1:0] RATRK_MASK_RST = 2'h0;

	// fraction scaling: one sign bit, fifteen fraction bits
	localparam int RATRK_FRAC = 15;

	typedef enum logic [1:0] {st_idle, st_update, st_lookup, st_error} ratrk_fsm_t;

endpackage : ratrk_pkg

// ### design/ratrk_trig_rom.sv
`timescale 1ns/1ns
// sine and cosine of a 7-bit phase, registered output
module ratrk_trig_rom import ratrk_pkg::*; (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// lookup
	input wire logic [RATRK_PHW-1:0] phase_i,
	output logic signed [15:0] sin_o,
	output logic signed [15:0] cos_o
);

	typedef struct packed {
		logic signed [15:0] s;
		logic signed [15:0] c;
	} ratrk_rom_t;

	ratrk_rom_t r, next_r;

	// quarter wave only, the other quadrants come by symmetry
	function automatic logic signed [15:0] quarter(input logic [5:0] i);
		logic [15:0] v;
		v = 16'h0000;
		case (i)
			6'h00: v = 16'h0000; 6'h01: v = 16'h0648; 6'h02: v = 16'h0c8c; 6'h03: v = 16'h12c8;
			6'h04: v = 16'h18f9; 6'h05: v = 16'h1f1a; 6'h06: v = 16'h2528; 6'h07: v = 16'h2b1f;
			6'h08: v = 16'h30fb; 6'h09: v = 16'h36ba; 6'h0a: v = 16'h3c57; 6'h0b: v = 16'h41ce;
			6'h0c: v = 16'h471c; 6'h0d: v = 16'h4c3f; 6'h0e: v = 16'h5133; 6'h0f: v = 16'h55f5;
			6'h10: v = 16'h5a82; 6'h11: v = 16'h5ed7; 6'h12: v = 16'h62f1; 6'h13: v = 16'h66cf;
			6'h14: v = 16'h6a6d; 6'h15: v = 16'h6dc9; 6'h16: v = 16'h70e2; 6'h17: v = 16'h73b5;
			6'h18: v = 16'h7641; 6'h19: v = 16'h7884; 6'h1a: v = 16'h7a7c; 6'h1b: v = 16'h7c29;
			6'h1c: v = 16'h7d89; 6'h1d: v = 16'h7e9c; 6'h1e: v = 16'h7f61; 6'h1f: v = 16'h7fd8;
			default: v = 16'h7fff;
		endcase
		return signed'(v);
	endfunction : quarter

	// full wave from quadrant bits
	function automatic logic signed [15:0] sine(input logic [6:0] p);
		logic [5:0] i;
		logic signed [15:0] m;
		i = p[5] ? (6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
		m = quarter(i);
		return p[6] ? -m : m;
	endfunction : sine

	always_comb begin
		next_r.s = sine(phase_i);
		next_r.c = sine(phase_i + 7'h20);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sin_o = r.s;
	assign cos_o = r.c;

endmodule : ratrk_trig_rom

// ### test/ratrk_tracker_props.sv
`timescale 1ns/1ns
// port-level checks on the tracker, bound into every instance
module ratrk_tracker_props import ratrk_pkg::*; (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [RATRK_AW-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	// samples and peer channel
	input wire logic signed [RATRK_DW-1:0] sin_sample_i,
	input wire logic signed [RATRK_DW-1:0] cos_sample_i,
	input wire logic link_req_i,
	input wire logic link_req_o,
	// results and requests
	input wire logic signed [RATRK_DW-1:0] angle_o,
	input wire logic signed [RATRK_DW-1:0] speed_o,
	input wire logic result_valid_o,
	input wire logic dma_req_o,
	input wire logic irq_o,
	input wire logic pwm_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic master_q;
	// last written master bit; pwm follows it on the same edge
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			master_q <= 1'b0;
		else if (wr_i && addr_i == RATRK_CTRL)
			master_q <= wdata_i[RATRK_CTRL_MASTER];
	end
	a_valid_spacing: assert property (result_valid_o |=> !result_valid_o [*3])
		else $error("result strobes closer than four cycles");
	a_dma_with_valid: assert property (dma_req_o == result_valid_o)
		else $error("transfer request apart from result strobe");
	a_link_at_end: assert property (link_req_o |-> result_valid_o)
		else $error("link request outside iteration end");
	a_angle_held: assert property (!result_valid_o |-> $stable(angle_o))
		else $error("angle moved between iterations");
	a_speed_held: assert property (!result_valid_o |-> $stable(speed_o))
		else $error("speed moved between iterations");
	a_compute_answer: assert property (wr_i && addr_i == RATRK_CMD && wdata_i[1:0] == 2'h1 |->
		##[4:12] result_valid_o)
		else $error("compute command gave no iteration");
	a_link_answer: assert property (link_req_i |-> ##[4:12] result_valid_o)
		else $error("incoming link gave no iteration");
	a_follower_quiet: assert property (!master_q && !$past(master_q) |-> !pwm_o)
		else $error("pwm active in follower mode");
	a_reset_aborts: assert property (wr_i && addr_i == RATRK_CMD && wdata_i[1:0] == 2'h2 && !link_req_i
		|=> !result_valid_o [*4])
		else $error("iteration finished after observer reset");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside read cycle");
endmodule : ratrk_tracker_props

bind ratrk_tracker ratrk_tracker_props i_props (
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.sin_sample_i(sin_sample_i),
	.cos_sample_i(cos_sample_i),
	.link_req_i(link_req_i),
	.link_req_o(link_req_o),
	.angle_o(angle_o),
	.speed_o(speed_o),
	.result_valid_o(result_valid_o),
	.dma_req_o(dma_req_o),
	.irq_o(irq_o),
	.pwm_o(pwm_o)
);

// ### test/ratrk_resolver_model.sv
`timescale 1ns/1ns
// converter samples of the two windings at quarter-turn shaft positions
module ratrk_resolver_model import ratrk_pkg::*; (
	// quadrant chosen by the bench
	input wire logic [1:0] pos_sel_i,
	// sampled amplitudes, held all the time the converter runs
	output logic signed [RATRK_DW-1:0] sin_o,
	output logic signed [RATRK_DW-1:0] cos_o
);
	// which channel is zero and the sign of the other carry the quadrant
	always_comb begin
		sin_o = pos_sel_i[0] ? 16'sh0000 : (pos_sel_i[1] ? 16'shc000 : 16'sh4000);
		cos_o = !pos_sel_i[0] ? 16'sh0000 : (pos_sel_i[1] ? 16'shc000 : 16'sh4000);
	end
endmodule : ratrk_resolver_model

// ### test/resolver_angle_tracker_bench.sv
`timescale 1ns/1ns
module resolver_angle_tracker_bench import ratrk_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [RATRK_AW-1:0] addr_i = 6'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic link_req_i = 1'b0;
	logic [1:0] pos_sel = 2'h0;
	logic [31:0] rdata_o;
	logic signed [RATRK_DW-1:0] sin_sample_i, cos_sample_i, angle_o, speed_o;
	logic link_req_o, result_valid_o, dma_req_o, irq_o, pwm_o;
	int err_total = 0;
	int comparisons = 0;
	int n_val, n_link, n_pwm, n_dma, nl;

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	ratrk_resolver_model i_res (.pos_sel_i(pos_sel), .sin_o(sin_sample_i), .cos_o(cos_sample_i));
	ratrk_tracker i_dut (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.sin_sample_i(sin_sample_i),
		.cos_sample_i(cos_sample_i),
		.link_req_i(link_req_i),
		.link_req_o(link_req_o),
		.angle_o(angle_o),
		.speed_o(speed_o),
		.result_valid_o(result_valid_o),
		.dma_req_o(dma_req_o),
		.irq_o(irq_o),
		.pwm_o(pwm_o)
	);

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one-cycle strobes, changed just after the edge
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rd

	// counts pulses and pwm high cycles over a window
	task automatic run(input int n);
		n_val = 0;
		n_link = 0;
		n_pwm = 0;
		n_dma = 0;
		// an unknown level counts as high so that it cannot hide behind a zero count
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
			n_val += (result_valid_o !== 1'b0);
			n_link += (link_req_o !== 1'b0);
			n_pwm += (pwm_o !== 1'b0);
			n_dma += (dma_req_o !== 1'b0);
		end
	endtask : run

	task automatic compute(input logic [15:0] ea, input logic [15:0] es);
		int i;
		wr(RATRK_CMD, 32'h1);
		for (i = 0; i < 20 && result_valid_o !== 1'b1; i++) begin
			@(posedge sys_clk_i);
			#1;
		end
		if (i == 20) begin
			err_total++;
			conclude();
		end
		chk({16'h0, angle_o}, {16'h0, ea});
		chk({16'h0, speed_o}, {16'h0, es});
	endtask : compute

	// hang guard
	initial begin
		#500000;
		err_total++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		rd(RATRK_CTRL, 32'h0);
		rd(RATRK_PERIOD, 32'h3e8);
		rd(RATRK_DUTY, 32'h1f4);
		rd(RATRK_GAIN1, 32'h4000);
		rd(RATRK_GAIN2, 32'h4000);
		rd(RATRK_RATE, 32'h0101);
		rd(RATRK_MASK, 32'h0);
		rd(6'h34, 32'h0);
		run(50);
		chk(n_pwm, 0);
		// error from sin 0.5 at estimate zero, then first speed step
		compute(16'h0, 16'h0);
		rd(RATRK_ERROR, 32'h3fff);
		// shaft at zero: only the cosine channel carries signal, estimate at phase step 7
		pos_sel <= 2'h1;
		compute(16'h0fff, 16'h1fff);
		rd(RATRK_ERROR, 32'hffffea70);
		wr(RATRK_CMD, 32'h2);
		rd(RATRK_ERROR, 32'h0);
		rd(RATRK_SPEED, 32'h1fff);
		chk({16'h0, angle_o}, 32'h0fff);
		// opposite half turn flips the error sign
		pos_sel <= 2'h2;
		compute(16'h0, 16'h0);
		rd(RATRK_ERROR, 32'hffffc000);
		wr(RATRK_CMD, 32'h2);
		pos_sel <= 2'h0;
		wr(RATRK_GAIN1, 32'h0001_4000);
		wr(RATRK_GAIN2, 32'h0001_4000);
		compute(16'h0, 16'h0);
		compute(16'h0ffe, 16'h0fff);
		// a single incoming link pulse
		@(posedge sys_clk_i);
		link_req_i <= 1'b1;
		@(posedge sys_clk_i);
		link_req_i <= 1'b0;
		run(12);
		chk(n_val, 1);
		chk(n_dma, 1);
		// request rates: interrupt every second, link every third
		wr(RATRK_CMD, 32'h2);
		wr(RATRK_RATE, 32'h0302);
		wr(RATRK_CTRL, 32'h4);
		rd(RATRK_STATUS, 32'h3);
		wr(RATRK_MASK, 32'h2);
		nl = 0;
		for (int k = 0; k < 6; k++) begin
			wr(RATRK_CMD, 32'h1);
			run(6);
			nl += n_link;
			if (k < 2)
				chk(irq_o, k);
		end
		chk(nl, 2);
		rd(RATRK_STATUS, 32'h3);
		chk(irq_o, 0);
		// master periodic: period 20, duty 5, start at 3
		wr(RATRK_PERIOD, 32'd20);
		wr(RATRK_DUTY, 32'd5);
		wr(RATRK_DELAY, 32'd3);
		wr(RATRK_CTRL, 32'h3);
		run(40);
		run(200);
		chk(n_val, 10);
		chk(n_pwm, 50);
		wr(RATRK_CTRL, 32'h0);
		run(5);
		run(50);
		chk(n_pwm, 0);
		conclude();
	end
endmodule : resolver_angle_tracker_bench
